//--- src/metrology_config_word.sv
/*
 * Bits 29 to 12 of the metrology configuration word and the datapath
 * steering it controls: wiring topology, phase B current derivation,
 * current sum, zero-crossing source, nominal voltage use, power settling
 * and dip/swell reporting modes.
 * Assumes the host SPI front end delivers decoded commands with a
 * checksum verdict, and that all inputs are synchronous to clk_sys_in.
 */

// Functional notes
// - Bit 29 set makes commands with a failed checksum be accepted; clear means they are refused.
// - Bit 28 set derives the phase B current as minus the sum of phase A and C currents.
// - Topology field 27..25 at 000 passes the measured phase voltages unchanged.
// - Topology 001 replaces phase B voltage by phase A minus phase C voltage.
// - Topology 010 sets phase B voltage to minus the sum of phase A and C voltages.
// - Topology 011 sets phase B voltage to minus the phase A voltage.
// - Topology 100 forms A as A-B, B as A-C and C as C-B voltages.
// - Field 24..22 picks auxiliary channel 0 to 5 for the current sum.
// - Sum formula 00 adds the three compensated phase currents.
// - Sum formula 01 adds the chosen auxiliary current to the phase sum.
// - Sum formula 10 at bits 21..20 subtracts the chosen auxiliary current from the phase sum.
// - Bit 19 selects repeated or entry/exit interrupts for the one-cycle detector.
// - Bit 18 selects repeated or entry/exit interrupts for the half-cycle detector.
// - Field 17..16 delays accumulation by 64, 128, 256 ms or not at all.
// - Bits 15, 14, 13 substitute the nominal voltage for phase C, B, A apparent power.
// - Bit 12 takes zero-crossing samples before the high-pass filter or after compensation.
`timescale 1ns/10ps
`include "metrology_config_map.svh"

module metrology_config_word #(
	parameter int          W                    = 32,
	parameter int unsigned SETTLE_64_CYCLES     = `SETTLE_64_MS * `CLK_RATE_KHZ,
	parameter int unsigned SETTLE_128_CYCLES    = `SETTLE_128_MS * `CLK_RATE_KHZ,
	parameter int unsigned SETTLE_256_CYCLES    = `SETTLE_256_MS * `CLK_RATE_KHZ
) (
	input  wire logic                  clk_sys_in,
	input  wire logic                  reset_n_in,
	input  wire logic                  host_cmd_valid_in,
	input  wire logic                  host_cmd_write_in,
	input  wire logic [15:0]           host_cmd_addr_in,
	input  wire logic [31:0]           host_cmd_wdata_in,
	input  wire logic                  host_cmd_crc_ok_in,
	output logic                       host_rsp_valid_out,
	output logic [31:0]                host_rsp_data_out,
	output logic                       host_cmd_reject_out,
	input  wire logic                  sample_valid_in,
	input  wire logic [W-1:0]          phase_a_voltage_in,
	input  wire logic [W-1:0]          phase_b_voltage_in,
	input  wire logic [W-1:0]          phase_c_voltage_in,
	input  wire logic [W-1:0]          phase_a_current_in,
	input  wire logic [W-1:0]          phase_b_current_in,
	input  wire logic [W-1:0]          phase_c_current_in,
	input  wire logic [2:0][W-1:0]     phase_compensated_current_in,
	input  wire logic [5:0][W-1:0]     auxiliary_compensated_current_in,
	input  wire logic [2:0][W-1:0]     zx_before_hpf_in,
	input  wire logic [2:0][W-1:0]     zx_after_pcf_in,
	input  wire logic [2:0][W-1:0]     voltage_rms_in,
	input  wire logic [W-1:0]          nominal_phase_voltage_in,
	output logic                       sample_valid_out,
	output logic [W-1:0]               phase_a_voltage_out,
	output logic [W-1:0]               phase_b_voltage_out,
	output logic [W-1:0]               phase_c_voltage_out,
	output logic [W-1:0]               phase_b_current_out,
	output logic [W-1:0]               current_sum_out,
	output logic [2:0][W-1:0]          zx_sample_out,
	output logic [2:0][W-1:0]          apparent_voltage_out,
	input  wire logic                  power_run_in,
	output logic                       accumulate_enable_out,
	input  wire logic                  sag_one_active_in,
	input  wire logic                  sag_one_count_in,
	input  wire logic                  sag_half_active_in,
	input  wire logic                  sag_half_count_in,
	output logic                       sag_one_irq_out,
	output logic                       sag_half_irq_out
);
	import metrology_config_pkg::*;

	// 24 bits hold the longest delay at the default clock rate
	localparam logic [23:0] LOAD_64  = 24'(SETTLE_64_CYCLES - 1);
	localparam logic [23:0] LOAD_128 = 24'(SETTLE_128_CYCLES - 1);
	localparam logic [23:0] LOAD_256 = 24'(SETTLE_256_CYCLES - 1);

	typedef struct packed {
		logic [31:0]          cfg;
		logic                 rsp_valid;
		logic [31:0]          rsp_data;
		logic                 reject;
		logic                 smp_valid;
		logic [W-1:0]         va;
		logic [W-1:0]         vb;
		logic [W-1:0]         vc;
		logic [W-1:0]         ib;
		logic [W-1:0]         current_sum;
		logic [2:0][W-1:0]    zx;
		logic [2:0][W-1:0]    app_v;
		settle_state_t        settle;
		logic [23:0]          count;
		logic                 accum;
	} cfg_state_t;

	cfg_state_t state;
	cfg_state_t next_state;

	// two's complement wrap at W bits; the datapath carries no saturation
	function automatic logic [W-1:0] neg_sum(input logic [W-1:0] x, input logic [W-1:0] y);
		neg_sum = W'(-(x + y));
	endfunction

	function automatic logic [W-1:0] pick_voltage(input logic use_nom,
		input logic [W-1:0] nom, input logic [W-1:0] rms);
		pick_voltage = use_nom ? nom : rms;
	endfunction

	function automatic logic [23:0] settle_load(input logic [1:0] sel);
		if (sel == `SETTLE_SEL_64) begin
			settle_load = LOAD_64;
		end else if (sel == `SETTLE_SEL_128) begin
			settle_load = LOAD_128;
		end else begin
			settle_load = LOAD_256;
		end
	endfunction

	logic [2:0]   topology;
	logic [2:0]   aux_pick;
	logic [1:0]   sum_formula;
	logic [1:0]   settle_sel;
	logic [W-1:0] aux_current;
	logic [W-1:0] phase_sum;
	logic         cmd_accept;

	assign topology    = state.cfg[`CFG_TOPOLOGY_HI:`CFG_TOPOLOGY_LO];
	assign aux_pick    = state.cfg[`CFG_NEUTRAL_HI:`CFG_NEUTRAL_LO];
	assign sum_formula = state.cfg[`CFG_SUM_FORMULA_HI:`CFG_SUM_FORMULA_LO];
	assign settle_sel  = state.cfg[`CFG_SETTLE_HI:`CFG_SETTLE_LO];
	// codes 110 and 111 have no channel; fall back to channel 0
	assign aux_current = (aux_pick <= 3'h5) ? auxiliary_compensated_current_in[aux_pick]
		: auxiliary_compensated_current_in[0];
	assign phase_sum = W'(phase_compensated_current_in[0] + phase_compensated_current_in[1]
		+ phase_compensated_current_in[2]);
	// with the check switched off even a bad checksum is taken
	assign cmd_accept = host_cmd_crc_ok_in | state.cfg[`CFG_CHECKSUM_DIS_BIT];

	always_comb begin
		next_state = state;
		next_state.rsp_valid = 1'b0;
		next_state.reject = 1'b0;
		next_state.smp_valid = sample_valid_in;

		// register access from the host port
		if (host_cmd_valid_in) begin
			if (!cmd_accept) begin
				next_state.reject = 1'b1;
			end else if (host_cmd_write_in) begin
				if (host_cmd_addr_in == `CFG_ZERO_OFFSET) begin
					next_state.cfg = host_cmd_wdata_in & `CFG_WRITE_MASK;
				end
			end else begin
				next_state.rsp_valid = 1'b1;
				if (host_cmd_addr_in == `CFG_ZERO_OFFSET) begin
					next_state.rsp_data = state.cfg;
				end else begin
					next_state.rsp_data = 32'h00000000;
				end
			end
		end

		if (sample_valid_in) begin
			next_state.va = phase_a_voltage_in;
			next_state.vb = phase_b_voltage_in;
			next_state.vc = phase_c_voltage_in;
			case (topology)
				`TOPO_DELTA_B: begin
					next_state.vb = W'(phase_a_voltage_in - phase_c_voltage_in);
				end
				`TOPO_WYE_NEG_SUM: begin
					next_state.vb = neg_sum(phase_a_voltage_in, phase_c_voltage_in);
				end
				`TOPO_WYE_NEG_A: begin
					next_state.vb = W'(-phase_a_voltage_in);
				end
				`TOPO_DELTA_ALL: begin
					next_state.va = W'(phase_a_voltage_in - phase_b_voltage_in);
					next_state.vb = W'(phase_a_voltage_in - phase_c_voltage_in);
					next_state.vc = W'(phase_c_voltage_in - phase_b_voltage_in);
				end
				default: begin
				end
			endcase

			if (state.cfg[`CFG_IB_DERIVE_BIT]) begin
				next_state.ib = neg_sum(phase_a_current_in, phase_c_current_in);
			end else begin
				next_state.ib = phase_b_current_in;
			end

			case (sum_formula)
				`SUM_PLUS_AUX: begin
					next_state.current_sum = W'(phase_sum + aux_current);
				end
				`SUM_MINUS_AUX: begin
					next_state.current_sum = W'(phase_sum - aux_current);
				end
				default: begin
					next_state.current_sum = phase_sum;
				end
			endcase

			next_state.zx = state.cfg[`CFG_ZX_SOURCE_BIT] ? zx_before_hpf_in
				: zx_after_pcf_in;
			next_state.app_v[0] = pick_voltage(state.cfg[`CFG_NOM_A_BIT],
				nominal_phase_voltage_in, voltage_rms_in[0]);
			next_state.app_v[1] = pick_voltage(state.cfg[`CFG_NOM_B_BIT],
				nominal_phase_voltage_in, voltage_rms_in[1]);
			next_state.app_v[2] = pick_voltage(state.cfg[`CFG_NOM_C_BIT],
				nominal_phase_voltage_in, voltage_rms_in[2]);
		end

		// settling: dropping power_run_in restarts the wait from the top
		case (state.settle)
			SETTLE_IDLE: begin
				next_state.accum = 1'b0;
				if (power_run_in) begin
					if (settle_sel == `SETTLE_SEL_NONE) begin
						next_state.settle = SETTLE_ACCUMULATE;
						next_state.accum = 1'b1;
					end else begin
						next_state.settle = SETTLE_WAIT;
						next_state.count = settle_load(settle_sel);
					end
				end
			end
			// loaded with N-1, so accumulation opens exactly N cycles after the start
			SETTLE_WAIT: begin
				if (!power_run_in) begin
					next_state.settle = SETTLE_IDLE;
				end else if (state.count == 24'h000000) begin
					next_state.settle = SETTLE_ACCUMULATE;
					next_state.accum = 1'b1;
				end else begin
					next_state.count = 24'(state.count - 24'h000001);
				end
			end
			SETTLE_ACCUMULATE: begin
				if (!power_run_in) begin
					next_state.settle = SETTLE_IDLE;
					next_state.accum = 1'b0;
				end
			end
			default: begin
				next_state.settle = SETTLE_IDLE;
				next_state.accum = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= '0;
			state.cfg <= `CFG_ZERO_RESET;
			state.settle <= SETTLE_IDLE;
		end else begin
			state <= next_state;
		end
	end

	logic one_irq;
	logic half_irq;

	dip_swell_reporter one_cycle_reporter (
		.clk_sys_in         (clk_sys_in),
		.reset_n_in         (reset_n_in),
		.entry_exit_mode_in (state.cfg[`CFG_ONE_CYC_MODE_BIT]),
		.condition_in       (sag_one_active_in),
		.count_reached_in   (sag_one_count_in),
		.irq_out            (one_irq)
	);

	dip_swell_reporter half_cycle_reporter (
		.clk_sys_in         (clk_sys_in),
		.reset_n_in         (reset_n_in),
		.entry_exit_mode_in (state.cfg[`CFG_HALF_CYC_MODE_BIT]),
		.condition_in       (sag_half_active_in),
		.count_reached_in   (sag_half_count_in),
		.irq_out            (half_irq)
	);

	assign host_rsp_valid_out    = state.rsp_valid;
	assign host_rsp_data_out     = state.rsp_data;
	assign host_cmd_reject_out   = state.reject;
	assign sample_valid_out      = state.smp_valid;
	assign phase_a_voltage_out   = state.va;
	assign phase_b_voltage_out   = state.vb;
	assign phase_c_voltage_out   = state.vc;
	assign phase_b_current_out   = state.ib;
	assign current_sum_out       = state.current_sum;
	assign zx_sample_out         = state.zx;
	assign apparent_voltage_out  = state.app_v;
	assign accumulate_enable_out = state.accum;
	assign sag_one_irq_out       = one_irq;
	assign sag_half_irq_out      = half_irq;

endmodule

//--- src/metrology_config_map.svh
/*
 * Offsets, field positions, reset values and timing figures of the
 * metrology configuration word. Assumes inclusion by bare name.
 */
`ifndef METROLOGY_CONFIG_MAP_SVH
`define METROLOGY_CONFIG_MAP_SVH

`define CFG_ZERO_OFFSET        16'h00AE
`define CFG_ZERO_RESET         32'h00000000
`define CFG_WRITE_MASK         32'h3FFFF000

`define CFG_CHECKSUM_DIS_BIT   29
`define CFG_IB_DERIVE_BIT      28
`define CFG_TOPOLOGY_HI        27
`define CFG_TOPOLOGY_LO        25
`define CFG_NEUTRAL_HI         24
`define CFG_NEUTRAL_LO         22
`define CFG_SUM_FORMULA_HI     21
`define CFG_SUM_FORMULA_LO     20
`define CFG_ONE_CYC_MODE_BIT   19
`define CFG_HALF_CYC_MODE_BIT  18
`define CFG_SETTLE_HI          17
`define CFG_SETTLE_LO          16
`define CFG_NOM_C_BIT          15
`define CFG_NOM_B_BIT          14
`define CFG_NOM_A_BIT          13
`define CFG_ZX_SOURCE_BIT      12

`define TOPO_WYE               3'h0
`define TOPO_DELTA_B           3'h1
`define TOPO_WYE_NEG_SUM       3'h2
`define TOPO_WYE_NEG_A         3'h3
`define TOPO_DELTA_ALL         3'h4

`define SUM_PHASES             2'h0
`define SUM_PLUS_AUX           2'h1
`define SUM_MINUS_AUX          2'h2

`define SETTLE_SEL_64          2'h0
`define SETTLE_SEL_128         2'h1
`define SETTLE_SEL_256         2'h2
`define SETTLE_SEL_NONE        2'h3

`define SETTLE_64_MS           64
`define SETTLE_128_MS          128
`define SETTLE_256_MS          256
`define CLK_RATE_KHZ           50000

`endif

//--- src/metrology_config_pkg.sv
/*
 * Types shared by the metrology configuration block.
 * Assumes the map header supplies the numeric constants.
 */
package metrology_config_pkg;

	typedef enum logic [1:0] {
		SETTLE_IDLE,
		SETTLE_WAIT,
		SETTLE_ACCUMULATE
	} settle_state_t;

endpackage

//--- src/dip_swell_reporter.sv
/*
 * Interrupt pulse generator for one dip/swell detector.
 * Assumes condition and count strobes are synchronous to clk_sys_in.
 */
`timescale 1ns/10ps

module dip_swell_reporter (
	input  wire logic clk_sys_in,
	input  wire logic reset_n_in,
	input  wire logic entry_exit_mode_in,
	input  wire logic condition_in,
	input  wire logic count_reached_in,
	output logic      irq_out
);
	import metrology_config_pkg::*;

	typedef struct packed {
		logic cond_prev;
		logic irq;
	} reporter_state_t;

	reporter_state_t state;
	reporter_state_t next_state;

	always_comb begin
		next_state = state;
		next_state.cond_prev = condition_in;
		if (entry_exit_mode_in) begin
			// one pulse on entering and one on leaving the condition
			next_state.irq = condition_in ^ state.cond_prev;
		end else begin
			// repeated pulse after every programmed cycle count
			next_state.irq = condition_in & count_reached_in;
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign irq_out = state.irq;

endmodule

//--- verification/metrology_config_word_properties.sv
/*
 * Checker for the metrology configuration word: host port and steering.
 * Assumes a bind onto metrology_config_word; sees its ports only.
 */
`timescale 1ns/10ps
`include "metrology_config_map.svh"

module metrology_config_word_checker #(
	parameter int W = 32
) (
	input wire logic         clk_sys_in,
	input wire logic         reset_n_in,
	input wire logic         host_cmd_valid_in,
	input wire logic         host_cmd_write_in,
	input wire logic [15:0]  host_cmd_addr_in,
	input wire logic [31:0]  host_cmd_wdata_in,
	input wire logic         host_cmd_crc_ok_in,
	input wire logic         host_rsp_valid_out,
	input wire logic [31:0]  host_rsp_data_out,
	input wire logic         host_cmd_reject_out,
	input wire logic         sample_valid_in,
	input wire logic [W-1:0] phase_a_current_in,
	input wire logic [W-1:0] phase_c_current_in,
	input wire logic [W-1:0] phase_b_current_out,
	input wire logic         power_run_in,
	input wire logic         accumulate_enable_out,
	input wire logic         sag_one_active_in,
	input wire logic         sag_one_count_in,
	input wire logic         sag_one_irq_out
);
	// shadow of the word, rebuilt from accepted writes only
	logic [31:0] cfg;
	logic        take;

	assign take = host_cmd_valid_in && host_cmd_addr_in == `CFG_ZERO_OFFSET
		&& (host_cmd_crc_ok_in || cfg[29]);

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in)
			cfg <= 32'h00000000;
		else if (take && host_cmd_write_in)
			cfg <= host_cmd_wdata_in & `CFG_WRITE_MASK;
	end

	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);

	a_crc_reject: assert property (
		host_cmd_valid_in && !host_cmd_crc_ok_in && !cfg[29]
		|=> host_cmd_reject_out && !host_rsp_valid_out) else $error("bad checksum not refused");
	a_rsp_cause: assert property (
		host_rsp_valid_out |-> $past(host_cmd_valid_in) && !$past(host_cmd_write_in))
		else $error("response without a read");
	a_read_back: assert property (
		take && !host_cmd_write_in |=> host_rsp_valid_out && host_rsp_data_out == $past(cfg))
		else $error("read data differs from word");
	a_reserved_zero: assert property (
		host_rsp_valid_out |-> (host_rsp_data_out & 32'hC0000FFF) == 32'h00000000)
		else $error("reserved bits not zero");
	a_ib_derive: assert property (
		sample_valid_in && cfg[28] |=> phase_b_current_out ==
		-($past(phase_a_current_in) + $past(phase_c_current_in))) else $error("phase b current");
	a_accum_drop: assert property (
		!power_run_in |=> !accumulate_enable_out) else $error("accumulation while stopped");
	a_irq_edge: assert property (
		cfg[19] && $changed(sag_one_active_in) |=> sag_one_irq_out) else $error("edge irq missing");
	a_irq_count: assert property (
		!cfg[19] |=> sag_one_irq_out == ($past(sag_one_active_in) && $past(sag_one_count_in)))
		else $error("count irq wrong");
endmodule

//--- verification/host_mcu_model.sv
/*
 * Host microcontroller model issuing decoded commands one at a time.
 * Assumes the device answers in the cycle after the taking edge.
 */
`timescale 1ns/10ps

module host_mcu_model (
	input  wire logic        clk_sys_in,
	input  wire logic        rsp_valid_in,
	input  wire logic [31:0] rsp_data_in,
	input  wire logic        reject_in,
	output logic             cmd_valid_out,
	output logic             cmd_write_out,
	output logic [15:0]      cmd_addr_out,
	output logic [31:0]      cmd_wdata_out,
	output logic             cmd_crc_ok_out
);
	initial begin
		{cmd_valid_out, cmd_write_out, cmd_crc_ok_out} = 3'h0;
		cmd_addr_out = 16'h0000;
		cmd_wdata_out = 32'h00000000;
	end

	task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
			input logic ok, output logic rv, output logic [31:0] rd, output logic rj);
		@(posedge clk_sys_in);
		cmd_valid_out <= 1'b1;
		cmd_write_out <= w;
		cmd_addr_out <= a;
		cmd_wdata_out <= d;
		cmd_crc_ok_out <= ok;
		@(posedge clk_sys_in);
		cmd_valid_out <= 1'b0;
		// idle lines must not look like a held command
		cmd_addr_out <= ~a;
		cmd_wdata_out <= ~d;
		#1;
		rv = rsp_valid_in;
		rd = rsp_data_in;
		rj = reject_in;
	endtask
endmodule

//--- verification/metrology_config_word_test.sv
/*
 * Self-checking bench for metrology_config_word driven by a host model.
 * Assumes settling counts shortened to 4, 8 and 16 cycles.
 */
`timescale 1ns/10ps
`include "metrology_config_map.svh"

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module metrology_config_word_test;
	localparam int W = 32;
	localparam logic [W-1:0] VA = 32'h64, VB = 32'h1E, VC = 32'h07;
	localparam logic [W-1:0] IA = 32'h0C, IB = 32'h05, IC = 32'h21;
	logic clk_sys_in, reset_n_in, host_cmd_valid_in, host_cmd_write_in, rv, rj;
	logic host_cmd_crc_ok_in, host_rsp_valid_out, host_cmd_reject_out;
	logic sample_valid_in, sample_valid_out, power_run_in, accumulate_enable_out;
	logic sag_one_active_in, sag_one_count_in, sag_one_irq_out;
	logic sag_half_active_in, sag_half_count_in, sag_half_irq_out;
	logic [15:0] host_cmd_addr_in;
	logic [31:0] host_cmd_wdata_in, host_rsp_data_out, rd;
	logic [W-1:0] phase_a_voltage_in, phase_b_voltage_in, phase_c_voltage_in;
	logic [W-1:0] phase_a_current_in, phase_b_current_in, phase_c_current_in;
	logic [W-1:0] phase_a_voltage_out, phase_b_voltage_out, phase_c_voltage_out;
	logic [W-1:0] nominal_phase_voltage_in, phase_b_current_out, current_sum_out;
	logic [2:0][W-1:0] phase_compensated_current_in, zx_before_hpf_in, zx_after_pcf_in;
	logic [2:0][W-1:0] voltage_rms_in, zx_sample_out, apparent_voltage_out;
	logic [5:0][W-1:0] auxiliary_compensated_current_in;
	int error_cnt, n_checks;

	metrology_config_word #(.SETTLE_64_CYCLES(4), .SETTLE_128_CYCLES(8), .SETTLE_256_CYCLES(16))
		i_dut (.*);
	host_mcu_model i_host (.clk_sys_in(clk_sys_in), .rsp_valid_in(host_rsp_valid_out),
		.rsp_data_in(host_rsp_data_out), .reject_in(host_cmd_reject_out),
		.cmd_valid_out(host_cmd_valid_in), .cmd_write_out(host_cmd_write_in),
		.cmd_addr_out(host_cmd_addr_in), .cmd_wdata_out(host_cmd_wdata_in),
		.cmd_crc_ok_out(host_cmd_crc_ok_in));

	initial begin
		clk_sys_in = 1'b0;
		forever #10 clk_sys_in = ~clk_sys_in;
	end

	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic wr(input logic [31:0] d);
		i_host.xfer(1'b1, `CFG_ZERO_OFFSET, d, 1'b1, rv, rd, rj);
	endtask

	task automatic rdk(input logic [15:0] a, input logic ok, input logic [31:0] e);
		i_host.xfer(1'b0, a, 32'h0, ok, rv, rd, rj);
		`CHK("read valid", 1'b1, rv)
		`CHK("read data", e, rd)
	endtask

	task automatic smp;
		@(posedge clk_sys_in);
		sample_valid_in <= 1'b1;
		@(posedge clk_sys_in);
		sample_valid_in <= 1'b0;
		#1;
	endtask

	task automatic t_reg;
		rdk(`CFG_ZERO_OFFSET, 1'b1, 32'h0);
		wr(32'hFFFFFFFF);
		rdk(`CFG_ZERO_OFFSET, 1'b1, `CFG_WRITE_MASK);
		rdk(16'h00AF, 1'b1, 32'h0);
		wr(32'h0);
		i_host.xfer(1'b1, `CFG_ZERO_OFFSET, 32'h10000000, 1'b0, rv, rd, rj);
		`CHK("refused", 1'b1, rj)
		rdk(`CFG_ZERO_OFFSET, 1'b1, 32'h0);
		wr(32'h20000000);
		i_host.xfer(1'b1, `CFG_ZERO_OFFSET, 32'h20001000, 1'b0, rv, rd, rj);
		`CHK("refused", 1'b0, rj)
		rdk(`CFG_ZERO_OFFSET, 1'b0, 32'h20001000);
		wr(32'h0);
	endtask

	task automatic t_topo;
		logic [W-1:0] ea, eb, ec;
		logic [31:0] c;
		// codes 101 to 111 must leave the voltages as measured
		for (int t = 0; t < 8; t++) begin
			c = (32'(t) << 25) | (32'(t) << 13) | (32'(t & 1) << 12);
			wr(c);
			smp();
			ea = (t == 4) ? VA - VB : VA;
			eb = (t == 1 || t == 4) ? VA - VC : (t == 2) ? -VA - VC : (t == 3) ? -VA : VB;
			ec = (t == 4) ? VC - VB : VC;
			`CHK("sample valid", 1'b1, sample_valid_out)
			`CHK("phase a v", ea, phase_a_voltage_out)
			`CHK("phase b v", eb, phase_b_voltage_out)
			`CHK("phase c v", ec, phase_c_voltage_out)
			`CHK("phase b i", IB, phase_b_current_out)
			`CHK("zx", c[12] ? zx_before_hpf_in : zx_after_pcf_in, zx_sample_out)
			for (int i = 0; i < 3; i++) begin
				ea = c[13 + i] ? nominal_phase_voltage_in : voltage_rms_in[i];
				`CHK("apparent v", ea, apparent_voltage_out[i])
			end
		end
		wr(32'h10000000);
		smp();
		`CHK("phase b i", -(IA + IC), phase_b_current_out)
	endtask

	task automatic t_sum;
		logic [W-1:0] e;
		for (int f = 0; f < 4; f++) begin
			for (int k = 0; k < 6; k++) begin
				wr((32'(f) << 20) | (32'(k) << 22));
				smp();
				e = 32'h70;
				if (f == 1)
					e = e + auxiliary_compensated_current_in[k];
				if (f == 2)
					e = e - auxiliary_compensated_current_in[k];
				`CHK("current sum", e, current_sum_out)
			end
		end
	endtask

	task automatic t_settle;
		int n;
		int exp_n[4] = '{4, 8, 16, 0};
		for (int s = 0; s < 4; s++) begin
			wr(32'(s) << 16);
			@(posedge clk_sys_in);
			power_run_in <= 1'b1;
			n = 0;
			@(posedge clk_sys_in);
			#1;
			while (accumulate_enable_out !== 1'b1 && n < 40) begin
				@(posedge clk_sys_in);
				#1;
				n++;
			end
			`CHK("settle cycles", exp_n[s], n)
			@(posedge clk_sys_in);
			power_run_in <= 1'b0;
			repeat (2) @(posedge clk_sys_in);
			#1;
			`CHK("accumulate off", 1'b0, accumulate_enable_out)
		end
	endtask

	task automatic pulse(input logic a, input logic c, input logic e1, input logic e2);
		@(posedge clk_sys_in);
		sag_one_active_in <= a;
		sag_half_active_in <= a;
		sag_one_count_in <= c;
		sag_half_count_in <= c;
		@(posedge clk_sys_in);
		sag_one_count_in <= 1'b0;
		sag_half_count_in <= 1'b0;
		#1;
		`CHK("one irq", e1, sag_one_irq_out)
		`CHK("half irq", e2, sag_half_irq_out)
	endtask

	// one detector in entry/exit mode while the other repeats on counts
	task automatic t_irq;
		logic e;
		for (int m = 0; m < 2; m++) begin
			e = (m == 1);
			wr(e ? 32'h00080000 : 32'h00040000);
			pulse(1'b1, 1'b0, e, !e);
			pulse(1'b1, 1'b1, !e, e);
			pulse(1'b0, 1'b0, e, !e);
		end
	endtask

	initial begin
		reset_n_in = 1'b0;
		sample_valid_in = 1'b0;
		power_run_in = 1'b0;
		{sag_one_active_in, sag_one_count_in, sag_half_active_in, sag_half_count_in} = 4'h0;
		{phase_a_voltage_in, phase_b_voltage_in, phase_c_voltage_in} = {VA, VB, VC};
		{phase_a_current_in, phase_b_current_in, phase_c_current_in} = {IA, IB, IC};
		phase_compensated_current_in = {32'h40, 32'h20, 32'h10};
		zx_before_hpf_in = {32'hB3, 32'hB2, 32'hB1};
		zx_after_pcf_in = {32'hA3, 32'hA2, 32'hA1};
		voltage_rms_in = {32'hC3, 32'hC2, 32'hC1};
		nominal_phase_voltage_in = 32'h77;
		for (int i = 0; i < 6; i++)
			auxiliary_compensated_current_in[i] = 32'h100 << i;
		repeat (12) @(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		t_reg();
		t_topo();
		t_sum();
		t_settle();
		t_irq();
		conclude();
	end

	// the whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk_sys_in);
		error_cnt++;
		conclude();
	end
endmodule

bind metrology_config_word metrology_config_word_checker #(.W(W)) i_chk (.*);
